// ==== bench/ahps_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahps_conv_model #(
  parameter int LAT = 12
) (
  input wire logic ref_clk,
  input wire ahps_pkg::ahps_conv_t conv_req,
  input wire logic [9:0] code_in,
  output logic conv_done = 1'b0,
  output logic [9:0] conv_code
);
  int cnt = 0;
  // code is only valid with done; inverted otherwise so a stale sample shows
  assign conv_code = conv_done ? code_in : ~code_in;
  always @(posedge ref_clk) begin
    conv_done <= (cnt == 1);
    if (conv_req.start) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : ahps_conv_model
`default_nettype wire

// ==== bench/ahps_host_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahps_host_port_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [9:0] shared_data_lines_in,
  input wire logic shared_data_lines_oe,
  input wire logic status_n,
  input wire ahps_pkg::ahps_conv_t conv_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic int_mode;
  logic wr_q;
  // flag-mode mirror taken at the pin edge, ahead of the design's sync delay
  always_ff @(posedge ref_clk) begin
    wr_q <= wr_n;
    if (rst) int_mode <= 1'b0;
    else if (wr_n && !wr_q && !sel_n) int_mode <= shared_data_lines_in[9];
  end
  AST_OE_CAUSE: assert property (shared_data_lines_oe |-> $past(!sel_n && !rd_n, 3))
    else $error("data port driven without selected read");
  AST_OE_ON: assert property ((!sel_n && !rd_n) [*4] |-> shared_data_lines_oe)
    else $error("selected read did not drive the port");
  AST_SEL_GATE: assert property (sel_n [*4] |-> !shared_data_lines_oe)
    else $error("port driven while not selected");
  AST_START_HOLD: assert property (conv_req.start |-> conv_req.hold)
    else $error("start without hold");
  AST_START_PULSE: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  AST_BUSY_LOW: assert property (!int_mode && conv_req.start |-> !status_n)
    else $error("busy not low during conversion");
  AST_INT_QUIET: assert property (int_mode && conv_req.start |-> status_n)
    else $error("interrupt low during conversion");
  AST_INT_CLEAR: assert property (int_mode && !status_n && !sel_n && $fell(rd_n) |-> ##[1:5] status_n)
    else $error("interrupt not cleared by read");
  AST_INT_WR_CLEAR: assert property (int_mode && !status_n && !sel_n && $fell(wr_n) |-> ##[1:5] status_n)
    else $error("interrupt not cleared by write");
  cover property (int_mode && !status_n && !sel_n && $fell(wr_n));
  cover property (conv_req.start);
  cover property (shared_data_lines_oe);
  cover property (int_mode && !status_n);
endmodule : ahps_host_port_assertions
`default_nettype wire

// ==== bench/ahps_host_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ahps_host_port_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n = 1'b1;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic host_en = 1'b0;
  logic [9:0] host_val = 10'h000;
  logic [9:0] code_in = 10'h000;
  logic [9:0] dout;
  logic [9:0] din;
  logic [9:0] conv_code;
  logic oe;
  logic status_n;
  logic conv_done;
  ahps_pkg::ahps_conv_t conv_req;
  int err_count = 0;
  int check_count = 0;
  always #25 ref_clk = ~ref_clk;
  // a released bus shows the inverse so stale data cannot match
  assign din = oe ? dout : (host_en ? host_val : ~host_val);
  ahps_host_port #(.ACQ_CYCLES(1)) uut (.ref_clk(ref_clk), .rst(rst), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n),
    .shared_data_lines_in(din), .shared_data_lines_out(dout), .shared_data_lines_oe(oe), .status_n(status_n),
    .conv_req(conv_req), .conv_done(conv_done), .conv_code(conv_code));
  ahps_conv_model u_conv (.ref_clk(ref_clk), .conv_req(conv_req), .code_in(code_in), .conv_done(conv_done),
    .conv_code(conv_code));
  task chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : cyc
  task host_write(input logic [9:0] v);
    sel_n = 1'b0;
    host_en = 1'b1;
    host_val = v;
    cyc(4);
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
    sel_n = 1'b1;
    host_en = 1'b0;
    cyc(1);
  endtask : host_write
  task rd(input logic s_n, input logic [9:0] exp);
    sel_n = s_n;
    rd_n = 1'b0;
    cyc(5);
    chk(s_n ? oe === 1'b0 : (oe === 1'b1 && dout === exp), "read data");
    rd_n = 1'b1;
    sel_n = 1'b1;
    cyc(5);
    chk(oe === 1'b0, "port not released");
  endtask : rd
  task wait_st(input logic v);
    int i;
    for (i = 0; i < 100 && status_n !== v; i++) cyc(1);
    chk(status_n === v, "status timeout");
  endtask : wait_st
  task automatic t_codes;
    logic [9:0] raw [5] = '{10'h000, 10'h200, 10'h3ff, 10'h3fe, 10'h001};
    logic [9:0] exp [5] = '{10'h200, 10'h000, 10'h1ff, 10'h1fe, 10'h201};
    for (int k = 0; k < 5; k++) begin
      code_in = raw[k];
      host_write(10'h007);
      chk(status_n === 1'b0, "busy not low");
      chk(conv_req.chan === 3'h7 && conv_req.hold === 1'b1 && conv_req.half_scale === 1'b0, "channel a request");
      wait_st(1'b1);
      rd(1'b0, exp[k]);
    end
  endtask : t_codes
  task t_dual;
    int i;
    code_in = 10'h3ff;
    host_write(10'h0ca);
    chk(conv_req.chan === 3'h2 && conv_req.half_scale === 1'b1, "first channel or half scale");
    for (i = 0; i < 100 && conv_done !== 1'b1; i++) cyc(1);
    // change the code only after the converter's done cycle has passed
    cyc(1);
    code_in = 10'h000;
    cyc(3);
    chk(status_n === 1'b0, "status moved between conversions");
    chk(conv_req.chan === 3'h1, "second channel not requested");
    wait_st(1'b1);
    rd(1'b0, 10'h1ff);
    rd(1'b0, 10'h200);
  endtask : t_dual
  task t_int;
    code_in = 10'h100;
    host_write(10'h200);
    chk(status_n === 1'b1, "interrupt low too early");
    wait_st(1'b0);
    rd(1'b1, 10'h000);
    chk(status_n === 1'b0, "unselected read cleared flag");
    rd(1'b0, 10'h300);
    chk(status_n === 1'b1, "read did not clear flag");
    host_write(10'h200);
    wait_st(1'b0);
    host_write(10'h300);
    chk(status_n === 1'b1, "write did not clear flag");
    chk(conv_req.power_down === 1'b1 && conv_req.hold === 1'b0, "power-down not passed on");
  endtask : t_int
  task results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    cyc(8);
    rst = 1'b0;
    cyc(2);
    chk(status_n === 1'b1 && oe === 1'b0 && conv_req === '0, "reset state");
    t_codes();
    t_dual();
    t_int();
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule : ahps_host_port_tb_top
bind ahps_host_port ahps_host_port_assertions u_chk (.ref_clk(ref_clk), .rst(rst), .sel_n(sel_n), .wr_n(wr_n),
  .rd_n(rd_n), .shared_data_lines_in(shared_data_lines_in), .shared_data_lines_oe(shared_data_lines_oe),
  .status_n(status_n), .conv_req(conv_req));
`default_nettype wire

// ==== common/ahps_defines.svh ====
`ifndef AHPS_DEFINES_SVH
`define AHPS_DEFINES_SVH

`define AHPS_DATA_W 10
`define AHPS_FLAG_MODE_POS 9
`define AHPS_POWER_DOWN_POS 8
`define AHPS_HALF_SCALE_POS 7
`define AHPS_DUAL_SAMPLE_POS 6
`define AHPS_CHAN_B_LSB 3
`define AHPS_CHAN_A_LSB 0
`define AHPS_CTRL_RESET 10'h000
`define AHPS_RESULT_RESET 10'h000
`define AHPS_SIGN_FLIP 10'h200
`define AHPS_ACQ_CYCLES 4

`endif

// ==== common/ahps_pkg.sv ====
`include "ahps_defines.svh"
package ahps_pkg;

  // field order matches the bit layout of the control word
  typedef struct packed {
    logic flag_mode_bit;
    logic power_down;
    logic half_scale;
    logic dual_sample_bit;
    logic [2:0] chan_b;
    logic [2:0] chan_a;
  } ahps_ctrl_t;

  // request to the analog converter
  typedef struct packed {
    logic hold;
    logic start;
    logic half_scale;
    logic power_down;
    logic [2:0] chan;
  } ahps_conv_t;

  typedef enum logic [2:0] {
    AHPS_IDLE,
    AHPS_ACQ,
    AHPS_CONV_A,
    AHPS_WAIT_A,
    AHPS_CONV_B,
    AHPS_WAIT_B
  } ahps_state_t;

endpackage : ahps_pkg

// ==== rtl/ahps_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ahps_defines.svh"

module ahps_host_port #(
  parameter int ACQ_CYCLES = `AHPS_ACQ_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [`AHPS_DATA_W-1:0] shared_data_lines_in,
  output logic [`AHPS_DATA_W-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe,
  output logic status_n,
  output ahps_pkg::ahps_conv_t conv_req,
  input wire logic conv_done,
  input wire logic [`AHPS_DATA_W-1:0] conv_code
);

  // pin synchronisers; stage one is read only by stage two
  // data rides the same two stages as the strobes, so the word taken at a write's
  // rising edge is the one that stood on the pins at that edge
  logic [2:0] strb_s1;
  logic [2:0] strb_s2;
  logic [2:0] strb_s3;
  logic [`AHPS_DATA_W-1:0] data_s1;
  logic [`AHPS_DATA_W-1:0] data_s2;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // idle-high after reset, so release never shows a false strobe edge
      strb_s1 <= 3'h7;
      strb_s2 <= 3'h7;
      strb_s3 <= 3'h7;
      data_s1 <= `AHPS_CTRL_RESET;
      data_s2 <= `AHPS_CTRL_RESET;
    end else begin
      strb_s1 <= {sel_n, wr_n, rd_n};
      strb_s2 <= strb_s1;
      strb_s3 <= strb_s2;
      data_s1 <= shared_data_lines_in;
      data_s2 <= data_s1;
    end
  end

  logic sel_lo;
  logic wr_rise;
  logic wr_fall;
  logic rd_fall;
  logic rd_lo;

  // select qualifies every strobe
  // edges compare stage two with stage three, two cycles after the pin moves
  assign sel_lo = ~strb_s2[2];
  assign wr_rise = sel_lo & strb_s2[1] & ~strb_s3[1];
  assign wr_fall = sel_lo & ~strb_s2[1] & strb_s3[1];
  assign rd_fall = sel_lo & ~strb_s2[0] & strb_s3[0];
  assign rd_lo = sel_lo & ~strb_s2[0];

  // offset-binary converter code to two's complement: midpoint 200 becomes 000,
  // top 3ff becomes 1ff, bottom 000 becomes 200
  function automatic logic [`AHPS_DATA_W-1:0] to_twos(input logic [`AHPS_DATA_W-1:0] code);
    to_twos = code ^ `AHPS_SIGN_FLIP;
  endfunction : to_twos

  ahps_pkg::ahps_ctrl_t ctrl;
  ahps_pkg::ahps_ctrl_t next_ctrl;
  ahps_pkg::ahps_state_t state;
  ahps_pkg::ahps_state_t next_state;
  logic [7:0] acq_cnt;
  logic [7:0] next_acq_cnt;
  logic [`AHPS_DATA_W-1:0] first_result_reg;
  logic [`AHPS_DATA_W-1:0] next_first_result_reg;
  logic [`AHPS_DATA_W-1:0] second_result_reg;
  logic [`AHPS_DATA_W-1:0] next_second_result_reg;
  logic rd_ptr;
  logic next_rd_ptr;
  logic done_flag;
  logic next_done_flag;
  logic next_status_n;
  logic [`AHPS_DATA_W-1:0] next_data_out;
  logic next_oe;
  ahps_pkg::ahps_conv_t next_conv_req;
  logic finish;

  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_acq_cnt = acq_cnt;
    next_first_result_reg = first_result_reg;
    next_second_result_reg = second_result_reg;
    next_rd_ptr = rd_ptr;
    next_done_flag = done_flag;
    next_conv_req = conv_req;
    next_conv_req.start = 1'b0;
    finish = 1'b0;

    unique case (state)
      ahps_pkg::AHPS_IDLE: begin
        // the last request stays put, so hold and channel do not wander between conversions
      end
      ahps_pkg::AHPS_ACQ: begin
        // acquisition counted in ref_clk cycles; the converter's own clock is not modelled
        next_conv_req.hold = 1'b0;
        if (acq_cnt == 8'(ACQ_CYCLES - 1)) begin
          next_conv_req.hold = 1'b1;
          next_conv_req.start = 1'b1;
          next_state = ahps_pkg::AHPS_WAIT_A;
        end else begin
          next_acq_cnt = acq_cnt + 8'h01;
        end
      end
      ahps_pkg::AHPS_CONV_A: begin
        next_state = ahps_pkg::AHPS_WAIT_A;
      end
      ahps_pkg::AHPS_WAIT_A: begin
        // the converter's code is trusted only in the cycle conv_done stands
        if (conv_done) begin
          next_first_result_reg = to_twos(conv_code);
          if (ctrl.dual_sample_bit) begin
            // status untouched here; second channel starts at once
            next_conv_req.chan = ctrl.chan_b;
            next_state = ahps_pkg::AHPS_CONV_B;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ahps_pkg::AHPS_CONV_B: begin
        next_conv_req.start = 1'b1;
        next_state = ahps_pkg::AHPS_WAIT_B;
      end
      ahps_pkg::AHPS_WAIT_B: begin
        if (conv_done) begin
          next_second_result_reg = to_twos(conv_code);
          finish = 1'b1;
        end
      end
      default: begin
        // codes outside the enum only after an upset; park in idle
        next_state = ahps_pkg::AHPS_IDLE;
      end
    endcase

    // a completion beats a falling strobe's clear in the same cycle; a write's rising edge still clears its flag
    if (finish) begin
      next_state = ahps_pkg::AHPS_IDLE;
      next_conv_req.hold = 1'b0;
      next_done_flag = 1'b1;
    end else if (wr_fall || rd_fall) begin
      next_done_flag = 1'b0;
    end

    if (rd_fall) begin
      // results alternate first, second while dual sampling
      next_rd_ptr = ctrl.dual_sample_bit ? ~rd_ptr : 1'b0;
    end

    if (wr_rise) begin
      // a write mid-conversion abandons it and, unless it sets power_down, starts again from acquisition
      next_ctrl = ahps_pkg::ahps_ctrl_t'(data_s2);
      next_rd_ptr = 1'b0;
      next_done_flag = 1'b0;
      next_acq_cnt = 8'h00;
      next_conv_req.hold = 1'b0;
      next_conv_req.start = 1'b0;
      next_conv_req.chan = next_ctrl.chan_a;
      next_conv_req.half_scale = next_ctrl.half_scale;
      next_conv_req.power_down = next_ctrl.power_down;
      // power-down aborts any conversion and starts none
      next_state = next_ctrl.power_down ? ahps_pkg::AHPS_IDLE : ahps_pkg::AHPS_ACQ;
    end

    // busy low while converting, or interrupt low once done
    if (next_ctrl.flag_mode_bit) begin
      next_status_n = ~next_done_flag;
    end else begin
      next_status_n = (next_state == ahps_pkg::AHPS_IDLE);
    end

    // the port follows the synced strobes, so it lets go three cycles after the host
    // does; the host must leave the lines alone for that long after a read
    next_oe = rd_lo;
    // the word is latched at the read's falling edge and held, so the pointer
    // stepping on to the other result cannot change it mid-read
    next_data_out = shared_data_lines_out;
    if (rd_fall) begin
      next_data_out = rd_ptr ? second_result_reg : first_result_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= ahps_pkg::ahps_ctrl_t'(`AHPS_CTRL_RESET);
      state <= ahps_pkg::AHPS_IDLE;
      acq_cnt <= 8'h00;
      first_result_reg <= `AHPS_RESULT_RESET;
      second_result_reg <= `AHPS_RESULT_RESET;
      rd_ptr <= 1'b0;
      done_flag <= 1'b0;
      status_n <= 1'b1;
      shared_data_lines_out <= `AHPS_RESULT_RESET;
      shared_data_lines_oe <= 1'b0;
      conv_req <= '0;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      acq_cnt <= next_acq_cnt;
      first_result_reg <= next_first_result_reg;
      second_result_reg <= next_second_result_reg;
      rd_ptr <= next_rd_ptr;
      done_flag <= next_done_flag;
      status_n <= next_status_n;
      shared_data_lines_out <= next_data_out;
      shared_data_lines_oe <= next_oe;
      conv_req <= next_conv_req;
    end
  end

endmodule : ahps_host_port
`default_nettype wire
